//--- logic/cpps_dev.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - reset release starts auto initialisation
// - init-busy driven low when init done
// - warning high before reset release
// - reset held 5 ms after supplies good
// - reference clock stable within 5 ms
// - clock may run before power
// - no i2c until init-busy low
// - i2c finished before request falls
// - normal park done within 20 ms
// - clock, supplies kept 20 ms after request
// - request fall starts power-down, high powers on
// - reset after park releases init-busy
// - warning low starts fast park
// - clock, supplies kept 32 us after warning
// - request high displays, low turns off
// - init-busy driven high right after release
// - init locks pll, then loads config
// - request not lowered during start-up
module cpps_dev (
	input wire logic REF_CLK,
	input wire logic NRST,
	cpps_if.dev LNK,
	output logic DISPLAY_ON,
	output logic MIRRORS_PARKED,
	output logic FAST_PARK
);
	// state codes live in the package; a local name keeps the struct short
	typedef cpps_pkg::cpps_dstate_t cpps_dstate_t;

	// whole state of the controller end
	// one packed word, so the reset value and next state match field by field
	typedef struct packed {
		logic [1:0] rst_s; // reset-release synchroniser
		logic [1:0] warn_s; // warning synchroniser
		logic [1:0] req_s; // request synchroniser
		logic req_prev; // synced request, one cycle back
		cpps_dstate_t st;
		logic [cpps_pkg::CW-1:0] cnt; // phase timer
		logic busy_oe; // init-busy driven
		logic busy_v; // init-busy level
		logic disp; // image output enabled
		logic parked; // mirrors parked
		logic fpark; // fast park in progress or done
	} cpps_dev_t;

	// registered state and the value it takes at the next edge
	cpps_dev_t s_q;
	cpps_dev_t s_d;

	// synchronised views of the three link inputs
	logic rst_ok; // synced reset released
	logic warn_ok; // synced warning inactive
	logic req_h; // synced request

	// only the second stage is read; reading the first would let a
	// metastable level reach several branches in the same cycle
	assign rst_ok = s_q.rst_s[1];
	assign warn_ok = s_q.warn_s[1];
	assign req_h = s_q.req_s[1];

	// next-state logic
	// no output is taken from here directly, so none can glitch
	always_comb begin
		// every field defaults to its held value, so no path leaves one open
		s_d = s_q;
		// first stage feeds only the second stage
		s_d.rst_s = {s_q.rst_s[0], LNK.system_reset_low};
		s_d.warn_s = {s_q.warn_s[0], LNK.early_park_warning_low};
		s_d.req_s = {s_q.req_s[0], LNK.power_request};
		// one cycle of history for the request edge detector
		s_d.req_prev = req_h;
		// phase timer runs down to zero and rests there
		if (s_q.cnt != '0) begin
			s_d.cnt = s_q.cnt - 1'b1;
		end
		// priority: link reset, then warning, then fast park, then sequence
		if (!rst_ok) begin
			// reset asserted: stop driving, pull-up takes it high
			s_d.st = cpps_pkg::DS_RESET;
			s_d.busy_oe = 1'b0;
			s_d.busy_v = 1'b1;
			s_d.disp = 1'b0;
			s_d.fpark = 1'b0;
		end else if (!warn_ok && s_q.st != cpps_pkg::DS_RESET && !s_q.fpark) begin
			// warning overrides the sequence, park at once
			// a warning during reset is ignored; init needs it high first
			s_d.fpark = 1'b1;
			s_d.disp = 1'b0;
			s_d.parked = 1'b0;
			s_d.cnt = cpps_pkg::CW'(cpps_pkg::FPARK_RUN_CYC);
		end else if (s_q.fpark) begin
			// fast park finishes inside the hold-up window
			// parked stays low until the timer has run out
			if (s_q.cnt == '0) begin
				s_d.parked = 1'b1;
				s_d.st = cpps_pkg::DS_PARKED;
			end
		end else begin
			case (s_q.st)
				// first cycle with the link reset released
				cpps_pkg::DS_RESET: begin
					// release: drive busy high, start pll lock
					s_d.st = cpps_pkg::DS_PLL;
					s_d.busy_oe = 1'b1;
					s_d.busy_v = 1'b1;
					s_d.parked = 1'b1;
					s_d.cnt = cpps_pkg::CW'(cpps_pkg::PLL_LOCK_CYC);
				end

				// pll lock always precedes the configuration load
				cpps_pkg::DS_PLL: begin
					if (s_q.cnt == '0) begin
						s_d.st = cpps_pkg::DS_LOAD;
						s_d.cnt = cpps_pkg::CW'(cpps_pkg::CFG_LOAD_CYC);
					end
				end

				// busy falls only once the configuration load ends
				cpps_pkg::DS_LOAD: begin
					if (s_q.cnt == '0) begin
						s_d.busy_v = 1'b0;
						s_d.st = cpps_pkg::DS_OFF;
					end
				end

				// init done, waiting for a power request
				cpps_pkg::DS_OFF: begin
					// level high powers on, request held low stays off
					if (req_h) begin
						s_d.st = cpps_pkg::DS_ON;
						s_d.disp = 1'b1;
						s_d.parked = 1'b0;
					end
				end

				// only a true falling edge parks, not a low level
				cpps_pkg::DS_ON: begin
					if (s_q.req_prev && !req_h) begin
						s_d.st = cpps_pkg::DS_NPARK;
						s_d.disp = 1'b0;
						s_d.cnt = cpps_pkg::CW'(cpps_pkg::NPARK_RUN_CYC);
					end
				end

				// display already off, mirrors settling
				cpps_pkg::DS_NPARK: begin
					// bounded well inside the 20 ms limit
					if (s_q.cnt == '0) begin
						s_d.parked = 1'b1;
						s_d.st = cpps_pkg::DS_PARKED;
					end
				end

				// parked until the link reset or a new request comes
				cpps_pkg::DS_PARKED: begin
					// wait for reset; a new request powers on again
					if (req_h && !s_q.req_prev) begin
						s_d.st = cpps_pkg::DS_ON;
						s_d.disp = 1'b1;
						s_d.parked = 1'b0;
					end
				end

				// illegal code: restart from reset and run init again
				default: begin
					s_d.st = cpps_pkg::DS_RESET;
				end
			endcase
		end
	end

	// state register, constants only under reset
	// the async clear never reads an input, so it cannot glitch the state
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			// quiet levels: busy undriven, display off, mirrors parked
			s_q <= '{
				rst_s: 2'h0,
				warn_s: 2'h0,
				req_s: 2'h0,
				req_prev: 1'b0,
				st: cpps_pkg::DS_RESET,
				cnt: '0,
				busy_oe: 1'b0,
				busy_v: 1'b1,
				disp: 1'b0,
				parked: 1'b1,
				fpark: 1'b0
			};
		end else begin
			s_q <= s_d;
		end
	end

	// link drive: busy level and its enable, both straight from flops
	assign LNK.init_busy_o = s_q.busy_v;
	assign LNK.init_busy_oe = s_q.busy_oe;

	// user-side status, all registered
	assign DISPLAY_ON = s_q.disp;
	assign MIRRORS_PARKED = s_q.parked;
	assign FAST_PARK = s_q.fpark;
endmodule
`default_nettype wire

//--- logic/cpps_pkg.sv
package cpps_pkg;
	// reference clock rate in kHz, period 100 ns
	localparam int unsigned CLK_KHZ = 10000;
	// supply-good to reset release, least, in ms
	localparam int unsigned RST_HOLD_MS = 5;
	localparam int unsigned RST_HOLD_CYC = RST_HOLD_MS * CLK_KHZ;
	// normal park completion bound, in ms
	localparam int unsigned NPARK_MS = 20;
	localparam int unsigned NPARK_CYC = NPARK_MS * CLK_KHZ;
	// fast park hold-up window, in us
	localparam int unsigned FPARK_US = 32;
	localparam int unsigned FPARK_CYC = (FPARK_US * CLK_KHZ) / 1000;
	// pll lock time of the device model, in cycles
	localparam int unsigned PLL_LOCK_CYC = 64;
	// flash configuration load time, in cycles
	localparam int unsigned CFG_LOAD_CYC = 256;
	// normal park duration actually used, below the bound
	localparam int unsigned NPARK_RUN_CYC = 1000;
	// fast park duration actually used, below the window
	localparam int unsigned FPARK_RUN_CYC = 160;
	// counter width
	localparam int unsigned CW = 32;
	// device sequencing states, one-hot
	typedef enum logic [6:0] {
		DS_RESET = 7'h01,
		DS_PLL = 7'h02,
		DS_LOAD = 7'h04,
		DS_OFF = 7'h08,
		DS_ON = 7'h10,
		DS_NPARK = 7'h20,
		DS_PARKED = 7'h40
	} cpps_dstate_t;
	// power-manager side states, one-hot
	typedef enum logic [5:0] {
		HS_HOLD = 6'h01,
		HS_INIT = 6'h02,
		HS_READY = 6'h04,
		HS_NDOWN = 6'h08,
		HS_FDOWN = 6'h10,
		HS_RESET = 6'h20
	} cpps_hstate_t;
endpackage

//--- logic/cpps_if.sv
`timescale 1ns/1ps
`default_nettype none
// link between power manager / host and the controller
interface cpps_if;
	logic system_reset_low; // active-low reset to controller
	logic early_park_warning_low; // active-low fast park warning
	logic power_request; // high requests power-on and image output
	logic init_busy_o; // controller drive value of init-busy
	logic init_busy_oe; // controller drives init-busy when high
	logic init_busy; // resolved wire, pulled up when undriven
	assign init_busy = init_busy_oe ? init_busy_o : 1'b1;
	modport dev (input system_reset_low, input early_park_warning_low, input power_request,
		output init_busy_o, output init_busy_oe);
	modport host (output system_reset_low, output early_park_warning_low, output power_request,
		input init_busy);
endinterface
`default_nettype wire

//--- logic/cpps_host.sv
`timescale 1ns/1ps
`default_nettype none
// power manager and host end of the sequencing link
module cpps_host #(
	parameter int unsigned HOLD_CYC = cpps_pkg::RST_HOLD_CYC,
	parameter int unsigned NDOWN_CYC = cpps_pkg::NPARK_CYC
) (
	input wire logic REF_CLK,
	input wire logic NRST,
	cpps_if.host LNK,
	input wire logic SUPPLY_GOOD,
	input wire logic POWER_FAIL,
	input wire logic USER_ON,
	input wire logic I2C_IDLE,
	output logic I2C_ALLOWED,
	output logic SUPPLY_OFF
);
	typedef cpps_pkg::cpps_hstate_t cpps_hstate_t;
	// whole state of the host end
	typedef struct packed {
		logic [1:0] busy_s; // init-busy synchroniser
		cpps_hstate_t st;
		logic [cpps_pkg::CW-1:0] cnt; // hold timer
		logic rst_low; // reset drive, active low
		logic warn_low; // warning drive, active low
		logic req; // power request drive
		logic i2c_ok; // host may talk i2c
		logic off; // supplies may be removed
	} cpps_host_t;

	cpps_host_t s_q;
	cpps_host_t s_d;
	logic busy; // synced init-busy

	assign busy = s_q.busy_s[1];

	// next-state logic
	always_comb begin
		s_d = s_q;
		s_d.busy_s = {s_q.busy_s[0], LNK.init_busy};
		if (s_q.cnt != '0) begin
			s_d.cnt = s_q.cnt - 1'b1;
		end
		case (s_q.st)
			cpps_pkg::HS_HOLD: begin
				// clock may already run; count only while supplies good
				s_d.warn_low = 1'b1;
				s_d.off = 1'b0;
				if (!SUPPLY_GOOD) begin
					s_d.cnt = cpps_pkg::CW'(HOLD_CYC);
				end else if (s_q.cnt == '0) begin
					s_d.rst_low = 1'b1;
					s_d.st = cpps_pkg::HS_INIT;
				end
			end
			cpps_pkg::HS_INIT: begin
				// request held high until init completes
				s_d.req = 1'b1;
				if (!busy) begin
					s_d.i2c_ok = 1'b1;
					s_d.st = cpps_pkg::HS_READY;
				end
			end
			cpps_pkg::HS_READY: begin
				if (POWER_FAIL) begin
					s_d.warn_low = 1'b0;
					s_d.i2c_ok = 1'b0;
					s_d.cnt = cpps_pkg::CW'(cpps_pkg::FPARK_CYC);
					s_d.st = cpps_pkg::HS_FDOWN;
				end else if (!USER_ON) begin
					// stop i2c first, lower request once idle
					s_d.i2c_ok = 1'b0;
					if (I2C_IDLE && !s_q.i2c_ok) begin
						s_d.req = 1'b0;
						s_d.cnt = cpps_pkg::CW'(NDOWN_CYC);
						s_d.st = cpps_pkg::HS_NDOWN;
					end
				end else begin
					s_d.req = 1'b1;
					s_d.i2c_ok = 1'b1;
				end
			end
			cpps_pkg::HS_NDOWN, cpps_pkg::HS_FDOWN: begin
				// reset and clock kept alive through the park window
				if (s_q.cnt == '0) begin
					s_d.rst_low = 1'b0;
					s_d.st = cpps_pkg::HS_RESET;
				end
			end
			cpps_pkg::HS_RESET: begin
				s_d.off = 1'b1;
				if (USER_ON && !POWER_FAIL) begin
					s_d.warn_low = 1'b1;
					s_d.cnt = cpps_pkg::CW'(HOLD_CYC);
					s_d.st = cpps_pkg::HS_HOLD;
				end
			end
			default: begin
				s_d.st = cpps_pkg::HS_HOLD;
			end
		endcase
	end

	// state register
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			s_q <= '{busy_s: 2'h3, st: cpps_pkg::HS_HOLD, cnt: cpps_pkg::CW'(HOLD_CYC),
				rst_low: 1'b0, warn_low: 1'b1, req: 1'b0, i2c_ok: 1'b0, off: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign LNK.system_reset_low = s_q.rst_low;
	assign LNK.early_park_warning_low = s_q.warn_low;
	assign LNK.power_request = s_q.req;
	assign I2C_ALLOWED = s_q.i2c_ok;
	assign SUPPLY_OFF = s_q.off;
endmodule
`default_nettype wire

//--- bench/cpps_chk.sv
`timescale 1ns/1ps
`default_nettype none
// watches the link between both ends
module cpps_chk (
	input wire logic REF_CLK,
	input wire logic NRST,
	input wire logic system_reset_low,
	input wire logic early_park_warning_low,
	input wire logic power_request,
	input wire logic init_busy_o,
	input wire logic init_busy_oe,
	input wire logic init_busy
);
	// cycles the warning has been low, saturating
	typedef struct packed {logic [9:0] wcnt;} cpps_cst_t;
	cpps_cst_t s_q;
	cpps_cst_t s_d;
	// count while low, clear once high again
	always_comb begin
		s_d = s_q;
		if (early_park_warning_low) begin
			s_d.wcnt = 10'h000;
		end else if (s_q.wcnt != 10'h3ff) begin
			s_d.wcnt = s_q.wcnt + 10'h001;
		end
	end
	// helper register
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!NRST);
	a_busy_drive_start: assert property ($rose(system_reset_low) |-> ##[2:4] init_busy_oe && init_busy_o)
		else $error("busy not driven after release");
	a_busy_hold_init: assert property ($rose(init_busy_oe) |-> init_busy [*8])
		else $error("busy dropped early");
	a_init_done_time: assert property ($rose(init_busy_oe) |-> ##[315:330] $fell(init_busy))
		else $error("init done at wrong time");
	a_busy_release_rst: assert property ($fell(system_reset_low) |-> ##[1:5] !init_busy_oe)
		else $error("busy still driven in reset");
	a_warn_high_rel: assert property ($rose(system_reset_low) |-> early_park_warning_low)
		else $error("release with warning low");
	a_fast_hold_rst: assert property ($fell(system_reset_low) |-> s_q.wcnt == 10'h000 || s_q.wcnt >= 10'h13f)
		else $error("reset too soon after warning");
	a_req_keep_rst: assert property ($fell(power_request) && system_reset_low |-> system_reset_low [*8])
		else $error("reset too soon after request fall");
	a_req_after_init: assert property ($fell(power_request) && system_reset_low |-> !init_busy)
		else $error("request dropped during init");
	cover property ($fell(init_busy));
	cover property ($fell(power_request) && system_reset_low);
	cover property ($fell(early_park_warning_low));
endmodule
`default_nettype wire

//--- bench/cpps_test.sv
`timescale 1ns/1ps
`default_nettype none
// both ends back to back, driven from the user side
module cpps_test;
	localparam int HOLD = 100; // shortened reset hold
	localparam int NDOWN = 2000; // shortened park hold
	localparam int BSY = 0, RST = 1, REQ = 2, PRK = 3, FST = 4, WRN = 5, I2C = 6, DSP = 7;
	logic ref_clk, nrst, supply_good, power_fail, user_on, i2c_idle;
	logic display_on, mirrors_parked, fast_park, i2c_allowed, supply_off;
	logic [7:0] mon; // watched lines, indexed by the names above
	int err_total = 0;
	int checks = 0;
	int cyc = 0;
	int n, m;
	cpps_if lnk ();
	cpps_dev u_cpps_dev (.REF_CLK(ref_clk), .NRST(nrst), .LNK(lnk.dev),
		.DISPLAY_ON(display_on), .MIRRORS_PARKED(mirrors_parked), .FAST_PARK(fast_park));
	cpps_host #(.HOLD_CYC(HOLD), .NDOWN_CYC(NDOWN)) u_cpps_host (.REF_CLK(ref_clk), .NRST(nrst),
		.LNK(lnk.host), .SUPPLY_GOOD(supply_good), .POWER_FAIL(power_fail), .USER_ON(user_on),
		.I2C_IDLE(i2c_idle), .I2C_ALLOWED(i2c_allowed), .SUPPLY_OFF(supply_off));
	cpps_chk u_cpps_chk (.REF_CLK(ref_clk), .NRST(nrst), .system_reset_low(lnk.system_reset_low),
		.early_park_warning_low(lnk.early_park_warning_low), .power_request(lnk.power_request),
		.init_busy_o(lnk.init_busy_o), .init_busy_oe(lnk.init_busy_oe), .init_busy(lnk.init_busy));
	assign mon = {display_on, i2c_allowed, lnk.early_park_warning_low, fast_park, mirrors_parked,
		lnk.power_request, lnk.system_reset_low, lnk.init_busy};
	// free-running clock, also through reset
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	task automatic fail(input string msg);
		err_total++;
		$display("[FAIL] %0t %s", $time, msg);
	endtask
	task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) fail($sformatf("got %h want %h", got, exp));
	endtask
	task automatic chk_cnt(input int got, input int lo, input int hi);
		checks++;
		if (got < lo || got > hi) fail($sformatf("count %0d not in %0d..%0d", got, lo, hi));
	endtask
	// bounded wait at falling edges for a watched line
	task automatic waitv(input int sel, input logic v, input int lim, output int cnt);
		cnt = 0;
		while (mon[sel] !== v && cnt < lim) begin
			@(negedge ref_clk);
			cnt++;
		end
		if (mon[sel] !== v) fail("wait ran out");
	endtask
	task automatic end_of_test();
		if (err_total == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// both ends in reset, supplies down
	task automatic do_reset();
		nrst = 1'b0;
		supply_good = 1'b0;
		user_on = 1'b0;
		power_fail = 1'b0;
		i2c_idle = 1'b1;
		repeat (3) @(negedge ref_clk);
		chk_vec({mon[BSY], lnk.init_busy_oe, display_on, mirrors_parked, fast_park, mon[RST],
			mon[WRN], mon[REQ]}, 8'h92);
		nrst = 1'b1;
	endtask
	// supplies up, init, display on
	task automatic power_up();
		supply_good = 1'b1;
		user_on = 1'b1;
		waitv(RST, 1'b1, 300, n);
		chk_cnt(n, HOLD, HOLD + 10);
		repeat (5) @(negedge ref_clk);
		chk_vec({4'h0, lnk.init_busy_oe, mon[BSY], i2c_allowed, mon[WRN]}, 8'h0d);
		waitv(BSY, 1'b0, 400, n);
		chk_cnt(n + 5, 320, 332);
		waitv(I2C, 1'b1, 8, n);
		chk_cnt(n, 1, 4);
		waitv(DSP, 1'b1, 20, n);
		chk_vec({6'h00, mirrors_parked, fast_park}, 8'h00);
	endtask
	// cut a hang short
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail("timeout");
			end_of_test();
		end
	end
	initial begin
		do_reset();
		power_up();
		// switch-off held while the bus is busy
		i2c_idle = 1'b0;
		user_on = 1'b0;
		repeat (20) @(negedge ref_clk);
		chk_vec({6'h00, supply_off, mon[REQ]}, 8'h01);
		i2c_idle = 1'b1;
		waitv(REQ, 1'b0, 50, n);
		chk_vec({7'h00, i2c_allowed}, 8'h00);
		// request fall passes two sync stages before the display drops
		waitv(DSP, 1'b0, 8, m);
		chk_cnt(m, 2, 4);
		waitv(PRK, 1'b1, 1100, n);
		n = n + m;
		chk_cnt(n, cpps_pkg::NPARK_RUN_CYC, cpps_pkg::NPARK_RUN_CYC + 10);
		chk_cnt(n, 1, cpps_pkg::NPARK_CYC);
		waitv(RST, 1'b0, 2200, m);
		chk_cnt(n + m, NDOWN, NDOWN + 10);
		waitv(BSY, 1'b1, 8, n);
		chk_cnt(n, 1, 6);
		chk_vec({7'h00, supply_off}, 8'h01);
		// fast park from a running display
		do_reset();
		power_up();
		power_fail = 1'b1;
		waitv(WRN, 1'b0, 10, n);
		waitv(FST, 1'b1, 8, n);
		chk_cnt(n, 2, 5);
		chk_vec({6'h00, display_on, mirrors_parked}, 8'h00);
		waitv(PRK, 1'b1, 200, m);
		n = n + m;
		chk_cnt(n, cpps_pkg::FPARK_RUN_CYC, cpps_pkg::FPARK_RUN_CYC + 8);
		waitv(RST, 1'b0, 400, m);
		chk_cnt(n + m, 319, 340);
		end_of_test();
	end
endmodule
`default_nettype wire
